// >>> verilog/ocs_clock_select.sv
/*
  Oscillator clock-source controller: crystal gain choice, crystal
  start-up counter, PLL enable and multiplier, internal oscillator
  enables with ready and stable status, tuning value, system clock
  source choice and oscillator pin functions, behind a Wishbone slave.
  Assumes a 125 MHz clk, analog oscillators that report running and
  stable as asynchronous levels, and power-up timer and wake signals
  from logic on clk.
*/
// The placing of the registers and register access over Wishbone were decided locally.
//
// Operation
// - Count 1024 crystal cycles before clock stable.
// - Start count after reset, timer, every wake.
// - Hold execution during count unless monitors enabled.
// - With monitors, run on internal oscillator meanwhile.
// - Multiplier bit set gives 3x, clear 4x.
// - PLL on by config or software; config dominates.
// - Crystal modes pick low, medium, high gain.
// - Secondary oscillator selectable at run time.
// - Config bit chooses second pin: I/O or clock out.
// - Internal oscillator by config default or software.
// - Internal mode frees first pin for I/O.
// - HF oscillator on for HF select and internal.
// - Ready flag shows HF oscillator running.
// - Stable flag shows HF within 0.5 percent.
// - Tuning is 7-bit two's complement, reset zero.
// - Tuning affects only HF-derived clocks.
// - Execution continues after tuning; no done flag.
// - Two sources: calibrated 16 MHz, uncalibrated 31 kHz.
// - Fast start-up oscillator runs before HF takes over.
// - External clock modes skip the start-up count.
// - PLL unavailable to internal when select is 1x.
`timescale 1ns/10ps

module ocs_clock_select #(
  parameter int XTAL_COUNT = ocs_pkg::OCS_XTAL_COUNT // Crystal cycles counted before ready.
) (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [3:0] wb_adr_i, // Wishbone byte address.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire ocs_pkg::ocs_cfg_t cfg_word, // Configuration word, static.
  input wire logic power_up_timer_expired, // Power-up timer has run out.
  input wire logic wake_pulse, // One-cycle wake-up from sleep.
  input wire logic osc_in_pin, // Crystal oscillator input.
  input wire logic hf_running_in, // HF oscillator running, async.
  input wire logic hf_stable_in, // HF oscillator settled, async.
  input wire logic lf_running_in, // LF oscillator running, async.
  output ocs_pkg::ocs_ctl_t ctl_o // Oscillator and pin controls.
);
  import ocs_pkg::*;

  localparam int CW = $clog2(XTAL_COUNT) + 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(XTAL_COUNT - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  typedef struct packed {
    logic cfg_loaded;
    ocs_cfg_t cfg;
    logic [1:0] clock_source_select;
    logic [3:0] ifreq;
    logic mult3;
    logic spll;
    logic [6:0] tune;
    ocs_xtal_st_t xst;
    logic [CW-1:0] cnt;
    logic osc_s1;
    logic osc_s2;
    logic osc_prev;
    logic hf_run_s1;
    logic hf_run_s2;
    logic hf_stb_s1;
    logic hf_stb_s2;
    logic lf_run_s1;
    logic lf_run_s2;
    logic ack;
    logic [31:0] rdata;
    ocs_ctl_t ctl;
  } ocs_state_t;

  localparam ocs_state_t ST_RESET = '{
    cfg_loaded: 1'b0, cfg: '0, clock_source_select: OCS_SCS_CONFIG, ifreq: OCS_IFREQ_RST,
    mult3: 1'b0, spll: 1'b0, tune: OCS_TUNE_RST, xst: OCS_ST_IDLE,
    cnt: '0, osc_s1: 1'b0, osc_s2: 1'b0, osc_prev: 1'b0,
    hf_run_s1: 1'b0, hf_run_s2: 1'b0, hf_stb_s1: 1'b0, hf_stb_s2: 1'b0,
    lf_run_s1: 1'b0, lf_run_s2: 1'b0, ack: 1'b0, rdata: '0,
    ctl: '{gain: OCS_GAIN_OFF, pll_en: 1'b0, pll_mult3: 1'b0, hf_en: 1'b0,
           lf_en: 1'b0, fast_startup: 1'b0, hf_tune: OCS_TUNE_RST,
           sys_src: OCS_SYS_PRIMARY, cpu_hold: 1'b1, ext_clk_ready: 1'b0,
           osc_in_gpio: 1'b0, osc_out_clkout: 1'b0, osc_out_gpio: 1'b0}
  };

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // True for the three crystal or resonator modes.
  function automatic logic is_xtal(input logic [2:0] src);
    is_xtal = (src == OCS_SRC_WATCH) || (src == OCS_SRC_MEDIUM) || (src == OCS_SRC_HIGH);
  endfunction : is_xtal

  // True for the logic-level external clock modes.
  function automatic logic is_ext(input logic [2:0] src);
    is_ext = (src > OCS_SRC_INTERNAL);
  endfunction : is_ext

  // Inverter-amplifier gain for a crystal mode.
  function automatic logic [1:0] gain_of(input logic [2:0] src);
    if (src == OCS_SRC_WATCH) begin
      gain_of = OCS_GAIN_LOW;
    end else if (src == OCS_SRC_MEDIUM) begin
      gain_of = OCS_GAIN_MED;
    end else if (src == OCS_SRC_HIGH) begin
      gain_of = OCS_GAIN_HIGH;
    end else begin
      gain_of = OCS_GAIN_OFF;
    end
  endfunction : gain_of

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1;
  logic rst_n_sync;

  // Reset is asserted at once but released through two flops, so that
  // the whole state struct leaves reset on the same edge.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n_sync <= rst_s1;
    end
  end

  ocs_state_t s_q;
  ocs_state_t s_d;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Computes bus answers, the start-up sequence and every control output.
  always_comb begin
    logic req;
    logic wr;
    logic osc_rise;
    logic xtal;
    logic monitors;
    logic int_on;
    logic hf_sel;
    logic fallback;
    req = 1'b0;
    wr = 1'b0;
    osc_rise = 1'b0;
    xtal = 1'b0;
    monitors = 1'b0;
    int_on = 1'b0;
    hf_sel = 1'b0;
    fallback = 1'b0;
    s_d = s_q;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Asynchronous inputs pass two flops before anything looks at them.
    s_d.osc_s1 = osc_in_pin;
    s_d.osc_s2 = s_q.osc_s1;
    s_d.osc_prev = s_q.osc_s2;
    s_d.hf_run_s1 = hf_running_in;
    s_d.hf_run_s2 = s_q.hf_run_s1;
    s_d.hf_stb_s1 = hf_stable_in;
    s_d.hf_stb_s2 = s_q.hf_stb_s1;
    s_d.lf_run_s1 = lf_running_in;
    s_d.lf_run_s2 = s_q.lf_run_s1;
    osc_rise = s_q.osc_s2 & ~s_q.osc_prev;

    // The configuration word is caught on the first edge after release.
    if (!s_q.cfg_loaded) begin
      s_d.cfg = cfg_word;
      s_d.cfg_loaded = 1'b1;
    end

    // ----------------------------------------------------------------
    // Register interface
    // ----------------------------------------------------------------
    // Wishbone: one wait state, ack for a single cycle, unmapped reads zero.
    req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    s_d.ack = req;
    // Read data stays registered until the next request, for a slow master.
    if (req) begin
      s_d.rdata = '0;
      if (wb_adr_i == OCS_ADDR_CTRL) begin
        s_d.rdata[OCS_CTRL_SCS_LSB +: 2] = s_q.clock_source_select;
        s_d.rdata[OCS_CTRL_IFREQ_LSB +: 4] = s_q.ifreq;
        s_d.rdata[OCS_CTRL_MULT_BIT] = s_q.mult3;
        s_d.rdata[OCS_CTRL_SPLL_BIT] = s_q.spll;
      end else if (wb_adr_i == OCS_ADDR_STAT) begin
        // Flags are gated by the enables so a stale running level is not shown.
        // ready flag
        s_d.rdata[OCS_STAT_HF_READY] = s_q.hf_run_s2 & s_q.ctl.hf_en;
        s_d.rdata[OCS_STAT_HF_STABLE] = s_q.hf_stb_s2 & s_q.hf_run_s2 & s_q.ctl.hf_en;
        s_d.rdata[OCS_STAT_LF_READY] = s_q.lf_run_s2 & s_q.ctl.lf_en;
        s_d.rdata[OCS_STAT_XTAL_READY] = s_q.ctl.ext_clk_ready;
        s_d.rdata[OCS_STAT_PLL_ON] = s_q.ctl.pll_en;
        s_d.rdata[OCS_STAT_CPU_HOLD] = s_q.ctl.cpu_hold;
      end else if (wb_adr_i == OCS_ADDR_TUNE) begin
        s_d.rdata[6:0] = s_q.tune;
      end else if (wb_adr_i == OCS_ADDR_CFG) begin
        s_d.rdata[7:0] = s_q.cfg;
      end
    end

    // Register writes; only byte lane 0 carries fields.
    if (wr) begin
      if (wb_adr_i == OCS_ADDR_CTRL) begin
        s_d.clock_source_select = wb_dat_i[OCS_CTRL_SCS_LSB +: 2];
        s_d.ifreq = wb_dat_i[OCS_CTRL_IFREQ_LSB +: 4];
        s_d.mult3 = wb_dat_i[OCS_CTRL_MULT_BIT];
        s_d.spll = wb_dat_i[OCS_CTRL_SPLL_BIT];
      end else if (wb_adr_i == OCS_ADDR_TUNE) begin
        // no completion flag
        // Bits above the seven-bit field are dropped.
        s_d.tune = wb_dat_i[6:0];
      end
    end

    // ----------------------------------------------------------------
    // Crystal start-up
    // ----------------------------------------------------------------
    xtal = s_q.cfg_loaded & is_xtal(s_q.cfg.clock_src);
    monitors = s_q.cfg.failsafe_en | s_q.cfg.two_speed_en;

    // Crystal start-up sequencer.
    case (s_q.xst)
      OCS_ST_IDLE: begin
        if (xtal) begin
          if (s_q.cfg.power_up_timer_en && !power_up_timer_expired) begin
            s_d.xst = OCS_ST_WAIT_POWER_UP_TIMER;
          end else begin
            s_d.xst = OCS_ST_COUNT;
          end
          s_d.cnt = CNT_ZERO;
        end else if (s_q.cfg_loaded && is_ext(s_q.cfg.clock_src)) begin
          s_d.xst = OCS_ST_READY;
        end else if (s_q.cfg_loaded) begin
          // RC and internal sources need no crystal settling either.
          s_d.xst = OCS_ST_READY;
        end
      end
      OCS_ST_WAIT_POWER_UP_TIMER: begin
        // The LF oscillator times the power-up timer and stays on meanwhile.
        if (power_up_timer_expired) begin
          s_d.xst = OCS_ST_COUNT;
          s_d.cnt = CNT_ZERO;
        end
      end
      OCS_ST_COUNT: begin
        // Edges are seen after the synchroniser, so the crystal must run well below clk.
        // count crystal cycles
        if (osc_rise) begin
          s_d.cnt = s_q.cnt + CNT_ONE;
          if (s_q.cnt == CNT_LAST) begin
            s_d.xst = OCS_ST_READY;
          end
        end
      end
      OCS_ST_READY: begin
        // Ready holds until a wake starts the count over.
        s_d.xst = OCS_ST_READY;
      end
      default: begin
        s_d.xst = OCS_ST_IDLE;
      end
    endcase

    // A wake in mid-count starts over; no partial count is kept.
    // restart on every wake
    if (wake_pulse && xtal) begin
      s_d.xst = OCS_ST_COUNT;
      s_d.cnt = CNT_ZERO;
    end

    // ----------------------------------------------------------------
    // Source and oscillator controls
    // ----------------------------------------------------------------
    // internal when config or select asks
    int_on = (s_q.cfg.clock_src == OCS_SRC_INTERNAL) | s_q.clock_source_select[1];
    // Fallback only under select 00, so an explicit run-time choice stays in charge.
    // internal fallback during count
    fallback = xtal & monitors & (s_q.xst != OCS_ST_READY) & (s_q.clock_source_select == OCS_SCS_CONFIG);
    hf_sel = (s_q.ifreq != OCS_IFREQ_LF);

    // Until the config word is caught the core is held, whatever the mode.
    // hold unless monitors enabled
    s_d.ctl.cpu_hold = ~s_q.cfg_loaded | ((s_q.xst != OCS_ST_READY) & ~(xtal & monitors));
    s_d.ctl.ext_clk_ready = (s_q.xst == OCS_ST_READY);

    if (s_q.clock_source_select == OCS_SCS_SECONDARY) begin
      s_d.ctl.sys_src = OCS_SYS_SECONDARY;
    end else if (int_on || fallback) begin
      s_d.ctl.sys_src = OCS_SYS_INTERNAL;
    end else begin
      s_d.ctl.sys_src = OCS_SYS_PRIMARY;
    end

    s_d.ctl.gain = s_q.cfg_loaded ? gain_of(s_q.cfg.clock_src) : OCS_GAIN_OFF;

    // no PLL when select is 1x
    s_d.ctl.pll_en = (s_q.cfg.pll_en | s_q.spll) & (s_q.clock_source_select == OCS_SCS_CONFIG) & s_q.cfg_loaded;
    s_d.ctl.pll_mult3 = s_q.mult3;

    s_d.ctl.hf_en = hf_sel & (int_on | fallback) & s_q.cfg_loaded;
    // The LF source also times the power-up timer and the fail-safe monitor.
    s_d.ctl.lf_en = ((~hf_sel & int_on) | s_q.cfg.failsafe_en | (s_q.xst == OCS_ST_WAIT_POWER_UP_TIMER))
                    & s_q.cfg_loaded;
    s_d.ctl.fast_startup = s_d.ctl.hf_en & ~s_q.hf_run_s2;
    s_d.ctl.hf_tune = s_q.tune;

    // ----------------------------------------------------------------
    // Pin functions
    // ----------------------------------------------------------------
    // first pin free in internal mode
    s_d.ctl.osc_in_gpio = s_q.cfg_loaded & (s_q.cfg.clock_src == OCS_SRC_INTERNAL);
    // second pin I/O or clock out
    s_d.ctl.osc_out_clkout = s_q.cfg_loaded & ~xtal & s_q.cfg.clkout_en;
    s_d.ctl.osc_out_gpio = s_q.cfg_loaded & ~xtal & ~s_q.cfg.clkout_en;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // All state but the two reset-release flops lives in one struct; reset loads the constant image.
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a field of the registered state, so none has a glitch.
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdata;
  assign ctl_o = s_q.ctl;

endmodule : ocs_clock_select

// >>> verilog/ocs_pkg.sv
/*
  Shared constants and types for the oscillator clock-source controller:
  register offsets and bit positions, configuration-word encodings, reset
  values, the crystal start-up count and the state and carrier types.
  Assumes nothing of its surroundings; it holds definitions only.
*/
package ocs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Wishbone bus)
  // ----------------------------------------------------------------
  localparam logic [3:0] OCS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] OCS_ADDR_STAT = 4'h4;
  localparam logic [3:0] OCS_ADDR_TUNE = 4'h8;
  localparam logic [3:0] OCS_ADDR_CFG = 4'hc;

  // Field positions in oscillator_control_reg.
  localparam int OCS_CTRL_SCS_LSB = 0;
  localparam int OCS_CTRL_IFREQ_LSB = 2;
  localparam int OCS_CTRL_MULT_BIT = 6;
  localparam int OCS_CTRL_SPLL_BIT = 7;

  // Bit positions in oscillator_status_reg.
  localparam int OCS_STAT_HF_READY = 0;
  localparam int OCS_STAT_HF_STABLE = 1;
  localparam int OCS_STAT_LF_READY = 2;
  localparam int OCS_STAT_XTAL_READY = 3;
  localparam int OCS_STAT_PLL_ON = 4;
  localparam int OCS_STAT_CPU_HOLD = 5;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] OCS_SRC_WATCH = 3'h0;
  localparam logic [2:0] OCS_SRC_MEDIUM = 3'h1;
  localparam logic [2:0] OCS_SRC_HIGH = 3'h2;
  localparam logic [2:0] OCS_SRC_RC = 3'h3;
  localparam logic [2:0] OCS_SRC_INTERNAL = 3'h4;
  localparam logic [1:0] OCS_SCS_CONFIG = 2'h0;
  localparam logic [1:0] OCS_SCS_SECONDARY = 2'h1;
  localparam logic [3:0] OCS_IFREQ_LF = 4'h0;
  localparam logic [3:0] OCS_IFREQ_RST = 4'h7;
  localparam logic [6:0] OCS_TUNE_RST = 7'h00;
  localparam logic [1:0] OCS_GAIN_OFF = 2'h0;
  localparam logic [1:0] OCS_GAIN_LOW = 2'h1;
  localparam logic [1:0] OCS_GAIN_MED = 2'h2;
  localparam logic [1:0] OCS_GAIN_HIGH = 2'h3;
  localparam int OCS_XTAL_COUNT = 1024;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OCS_SYS_PRIMARY = 2'h0,
    OCS_SYS_SECONDARY = 2'h1,
    OCS_SYS_INTERNAL = 2'h2
  } ocs_sys_src_t;

  typedef enum logic [3:0] {
    OCS_ST_IDLE = 4'h1,
    OCS_ST_WAIT_POWER_UP_TIMER = 4'h2,
    OCS_ST_COUNT = 4'h4,
    OCS_ST_READY = 4'h8
  } ocs_xtal_st_t;

  // Non-volatile configuration word, caught once after reset release.
  typedef struct packed {
    logic [2:0] clock_src;
    logic pll_en;
    logic clkout_en;
    logic failsafe_en;
    logic two_speed_en;
    logic power_up_timer_en;
  } ocs_cfg_t;

  // Controls driven to the analog oscillators, clock mux and pins.
  typedef struct packed {
    logic [1:0] gain;
    logic pll_en;
    logic pll_mult3;
    logic hf_en;
    logic lf_en;
    logic fast_startup;
    logic [6:0] hf_tune;
    ocs_sys_src_t sys_src;
    logic cpu_hold;
    logic ext_clk_ready;
    logic osc_in_gpio;
    logic osc_out_clkout;
    logic osc_out_gpio;
  } ocs_ctl_t;

endpackage : ocs_pkg

// >>> bench/ocs_clock_select_props.sv
/*
  Checker for the clock-source controller, bound to its top ports.
  Assumes a Wishbone master that drops cyc and stb after each ack.
*/
`timescale 1ns/10ps
module ocs_clock_select_props #(
  parameter int XTAL_COUNT = ocs_pkg::OCS_XTAL_COUNT // Crystal count.
) (
  input wire logic clk, // Clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic [3:0] wb_adr_i, // Address.
  input wire logic [31:0] wb_dat_i, // Write data.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_we_i, // Write enable.
  input wire logic [3:0] wb_sel_i, // Byte selects.
  input wire logic wb_cyc_i, // Cycle.
  input wire logic wb_stb_i, // Strobe.
  input wire logic wb_ack_o, // Acknowledge.
  input wire ocs_pkg::ocs_cfg_t cfg_word, // Config word.
  input wire logic power_up_timer_expired, // Timer done.
  input wire logic wake_pulse, // Wake.
  input wire logic osc_in_pin, // Crystal input.
  input wire logic hf_running_in, // HF running.
  input wire logic hf_stable_in, // HF stable.
  input wire logic lf_running_in, // LF running.
  input wire ocs_pkg::ocs_ctl_t ctl_o // Controls.
);
  import ocs_pkg::*;
  logic [3:0] quiet_q; // Cycles since reset or last write.
  logic [7:0] ctrl_q; // Shadow of the control register.
  logic [6:0] tune_q; // Shadow of the tuning register.
  logic wr; // Write taken this edge.
  logic settled; // Outputs have had time to follow.
  logic [1:0] gain_x; // Gain implied by the config word.
  logic mon; // Fail-safe or two-speed start-up on.
  logic xtal; // Crystal mode configured.
  // Shadows copy writes; outputs lag by up to two cycles, so wait 15.
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & !wb_ack_o;
  assign settled = (quiet_q == 4'hf);
  assign mon = cfg_word.failsafe_en | cfg_word.two_speed_en;
  assign xtal = (cfg_word.clock_src <= OCS_SRC_HIGH);
  assign gain_x = (cfg_word.clock_src == OCS_SRC_WATCH) ? OCS_GAIN_LOW :
    (cfg_word.clock_src == OCS_SRC_MEDIUM) ? OCS_GAIN_MED :
    (cfg_word.clock_src == OCS_SRC_HIGH) ? OCS_GAIN_HIGH : OCS_GAIN_OFF;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_q <= 4'h0;
      ctrl_q <= 8'h1c;
      tune_q <= 7'h00;
    end else begin
      quiet_q <= wr ? 4'h0 : (settled ? quiet_q : quiet_q + 4'h1);
      if (wr && wb_adr_i == OCS_ADDR_CTRL) ctrl_q <= wb_dat_i[7:0];
      if (wr && wb_adr_i == OCS_ADDR_TUNE) tune_q <= wb_dat_i[6:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_drop;
    ##[1:4] (!ctl_o.ext_clk_ready && ctl_o.cpu_hold);
  endsequence
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##1 s_pulse)
    else $error("ack missing or too long");
  AST_MULT: assert property (settled |-> ctl_o.pll_mult3 == ctrl_q[6])
    else $error("pll multiplier wrong");
  AST_PLL: assert property (settled |-> ctl_o.pll_en == ((cfg_word.pll_en | ctrl_q[7]) && ctrl_q[1:0] == 2'h0))
    else $error("pll enable wrong");
  AST_GAIN: assert property (settled |-> ctl_o.gain == gain_x)
    else $error("gain wrong");
  AST_TUNE: assert property (settled |-> ctl_o.hf_tune == tune_q)
    else $error("tune wrong");
  AST_HF_EN: assert property (settled && !mon |->
    ctl_o.hf_en == (ctrl_q[5:2] != 4'h0 && (cfg_word.clock_src == OCS_SRC_INTERNAL || ctrl_q[1])))
    else $error("hf enable wrong");
  AST_SECOND: assert property (settled && ctrl_q[1:0] == OCS_SCS_SECONDARY |-> ctl_o.sys_src == OCS_SYS_SECONDARY)
    else $error("secondary not chosen");
  AST_INTERNAL: assert property (settled &&
    (ctrl_q[1] || (cfg_word.clock_src == OCS_SRC_INTERNAL && ctrl_q[1:0] == 2'h0)) |-> ctl_o.sys_src == OCS_SYS_INTERNAL)
    else $error("internal not chosen");
  AST_WAKE: assert property (settled && wake_pulse && xtal && !mon |-> s_drop)
    else $error("wake did not restart");
  AST_MON: assert property (settled && mon |-> !ctl_o.cpu_hold)
    else $error("held with monitor on");
  AST_EXT: assert property (settled && cfg_word.clock_src > OCS_SRC_INTERNAL |-> ctl_o.ext_clk_ready)
    else $error("external clock delayed");
  AST_PINS: assert property (settled && cfg_word.clock_src == OCS_SRC_INTERNAL |->
    ctl_o.osc_in_gpio && ctl_o.osc_out_clkout == cfg_word.clkout_en)
    else $error("pin use wrong");
endmodule : ocs_clock_select_props

// >>> bench/ocs_clock_select_test.sv
/*
  Self-checking bench for the clock-source controller.
  Drives Wishbone, config word and oscillator inputs directly.
*/
`timescale 1ns/10ps
module ocs_clock_select_test;
  import ocs_pkg::*;
  localparam int XC = 8; // Short crystal count keeps the run brief.
  logic clk, reset_n, we, cyc, stb, power_up_timer, wake, osc_run, hf_run, hf_stb, lf_run, ack;
  logic osc = 1'b0;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [2:0] div = 3'h0;
  logic [7:0] wv [4];
  logic [4:0] ev [4];
  int rises = 0;
  int base, mismatches, check_count;
  ocs_cfg_t cfg;
  ocs_ctl_t ctl;
  ocs_clock_select #(.XTAL_COUNT(XC)) u_ocs_clock_select (.clk(clk), .reset_n(reset_n), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .cfg_word(cfg), .power_up_timer_expired(power_up_timer), .wake_pulse(wake), .osc_in_pin(osc),
    .hf_running_in(hf_run), .hf_stable_in(hf_stb), .lf_running_in(lf_run), .ctl_o(ctl));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Crystal runs at clk/16 so the two-flop sync never misses an edge.
  always @(posedge clk) begin
    div <= div + 3'h1;
    if (div == 3'h7) osc <= osc_run & ~osc;
    if (div == 3'h7 && osc_run && !osc) rises <= rises + 1;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("bus ack", ack, 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer
  task automatic do_reset(input logic [7:0] c);
    @(posedge clk);
    reset_n <= 1'b0;
    cfg <= c;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (14) @(posedge clk);
  endtask : do_reset
  // Runs the crystal until ready; the count of rises must be exact.
  task automatic xtal_run();
    int n;
    n = 0;
    base = rises;
    osc_run <= 1'b1;
    while (ctl.ext_clk_ready !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk("xtal rises", rises - base, XC);
    osc_run <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : xtal_run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    {reset_n, we, cyc, stb, power_up_timer, wake, osc_run, hf_run, hf_stb, lf_run} = 10'h000;
    {adr, wdat, mismatches, check_count} = '0;
    sel = 4'hf;
    cfg = '0;
    wv = '{8'hc0, 8'h9c, 8'h9e, 8'h1d};
    ev = '{5'b11010, 5'b10110, 5'b00110, 5'b00101};
    // Medium crystal waits for the power-up timer, then counts.
    do_reset({OCS_SRC_MEDIUM, 5'h01});
    chk("gain", ctl.gain, OCS_GAIN_MED);
    osc_run <= 1'b1;
    repeat (200) @(posedge clk);
    chk("early ready", ctl.ext_clk_ready, 1'b0);
    chk("hold", ctl.cpu_hold, 1'b1);
    osc_run <= 1'b0;
    repeat (40) @(posedge clk);
    power_up_timer <= 1'b1;
    xtal_run();
    chk("released", ctl.cpu_hold, 1'b0);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (5) @(posedge clk);
    chk("wake drop", ctl.ext_clk_ready, 1'b0);
    xtal_run();
    for (int i = 0; i < 2; i++) begin
      do_reset(i ? {OCS_SRC_HIGH, 5'h02} : {OCS_SRC_WATCH, 5'h04});
      chk("gain", ctl.gain, i ? OCS_GAIN_HIGH : OCS_GAIN_LOW);
      chk("lf on", ctl.lf_en, i ? 1'b0 : 1'b1);
      chk("run int", {ctl.cpu_hold, ctl.sys_src}, OCS_SYS_INTERNAL);
      xtal_run();
      chk("run pri", ctl.sys_src, OCS_SYS_PRIMARY);
    end
    do_reset({3'h7, 5'h01});
    chk("ext", {ctl.ext_clk_ready, ctl.cpu_hold}, 2'b10);
    // Internal mode with clock out: pins, status and registers.
    do_reset({OCS_SRC_INTERNAL, 5'h08});
    chk("fast start", ctl.fast_startup, 1'b1);
    hf_run <= 1'b1;
    repeat (4) @(posedge clk);
    chk("fast done", ctl.fast_startup, 1'b0);
    chk("pins", {ctl.osc_in_gpio, ctl.osc_out_clkout, ctl.osc_out_gpio}, 3'b110);
    xfer(OCS_ADDR_CTRL, 1'b0, 0);
    chk("ctrl rst", q, 32'h1c);
    xfer(OCS_ADDR_CFG, 1'b1, 32'hff);
    xfer(OCS_ADDR_CFG, 1'b0, 0);
    chk("cfg view", q, 32'h88);
    xfer(4'h2, 1'b0, 0);
    chk("unmapped", q, 32'h0);
    xfer(OCS_ADDR_STAT, 1'b0, 0);
    chk("hf ready", q, 32'h09);
    hf_stb <= 1'b1;
    xfer(OCS_ADDR_TUNE, 1'b0, 0);
    chk("tune rst", q, 32'h0);
    xfer(OCS_ADDR_STAT, 1'b0, 0);
    chk("hf stable", q, 32'h0b);
    for (int i = 1; i < 4; i++) begin
      xfer(OCS_ADDR_TUNE, 1'b1, {24'h0, wv[i] ^ 8'h23});
      xfer(OCS_ADDR_TUNE, 1'b0, 0);
      chk("tune", q, {25'h0, wv[i][6:0] ^ 7'h23});
      chk("tune out", ctl.hf_tune, wv[i][6:0] ^ 7'h23);
    end
    xfer(OCS_ADDR_TUNE, 1'b1, 32'h40);
    repeat (2) @(posedge clk);
    chk("tune min", ctl.hf_tune, 7'h40);
    for (int i = 0; i < 4; i++) begin
      xfer(OCS_ADDR_CTRL, 1'b1, {24'h0, wv[i]});
      repeat (4) @(posedge clk);
      chk("ctl", {ctl.pll_en, ctl.pll_mult3, ctl.hf_en, ctl.sys_src}, ev[i]);
    end
    do_reset({OCS_SRC_INTERNAL, 5'h10});
    chk("cfg pll", {ctl.pll_en, ctl.osc_out_gpio}, 2'b11);
    print_verdict();
  end
endmodule : ocs_clock_select_test
bind ocs_clock_select ocs_clock_select_props #(.XTAL_COUNT(XTAL_COUNT)) u_ocs_clock_select_props (.clk(clk),
  .reset_n(reset_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cfg_word(cfg_word),
  .power_up_timer_expired(power_up_timer_expired), .wake_pulse(wake_pulse), .osc_in_pin(osc_in_pin), .hf_running_in(hf_running_in),
  .hf_stable_in(hf_stable_in), .lf_running_in(lf_running_in), .ctl_o(ctl_o));
